/* File: sbg_pkg.sv */
`default_nettype none

package sbg_pkg;

	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned NS_PER_MS = 1000000;
	localparam int unsigned NS_PER_US = 1000;

	// Clock-low and data-low timeout window, in milliseconds.
	localparam int unsigned TIMEOUT_MIN_MS = 25;
	localparam int unsigned TIMEOUT_MAX_MS = 35;
	localparam int unsigned TIMEOUT_SET_MS = 30;
	localparam int unsigned TIMEOUT_MIN_CYC = (TIMEOUT_MIN_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TIMEOUT_MAX_CYC = (TIMEOUT_MAX_MS * NS_PER_MS) / CLK_PERIOD_NS;
	localparam int unsigned TIMEOUT_SET_CYC = (TIMEOUT_SET_MS * NS_PER_MS) / CLK_PERIOD_NS;
	localparam int unsigned TIMER_W = 19;

	// Longest spike to reject in the fast class, in nanoseconds.
	localparam int unsigned SPIKE_NS = 50;
	localparam int unsigned SPIKE_RAW = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SPIKE_CYC = (SPIKE_RAW < 1) ? 1 : SPIKE_RAW;

	// Both lines high for longer than this means the bus is free.
	localparam int unsigned IDLE_US = 50;
	localparam int unsigned IDLE_CYC = (IDLE_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned IDLE_W = 10;

	// Values after reset.
	localparam logic RST_LINE = 1'b1;
	localparam logic RST_PULSE = 1'b0;
	localparam logic [2:0] RST_MODE = 3'h0;

	typedef enum logic [2:0] {
		SBG_MODE_OFF = 3'b000,
		SBG_MODE_I2C = 3'b001,
		SBG_MODE_SMBUS = 3'b010,
		SBG_MODE_SPI = 3'b011,
		SBG_MODE_MASTER = 3'b100
	} sbg_mode_e;

	typedef enum logic [1:0] {
		SBG_ST_IDLE = 2'b00,
		SBG_ST_FRAME = 2'b01,
		SBG_ST_RECOVER = 2'b10
	} sbg_state_e;

endpackage

`default_nettype wire

/* File: sbg_timer_if.sv */
`default_nettype none

interface sbg_timer_if;
	logic line_low;
	logic line_edge;
	logic expired;
	modport timer(input line_low, input line_edge, output expired);
	modport user(output line_low, output line_edge, input expired);
endinterface

`default_nettype wire

/* File: sbg_low_timer.sv */
`default_nettype none

module sbg_low_timer import sbg_pkg::*; #(
	parameter int unsigned CNT_W = TIMER_W,
	parameter int unsigned LIMIT = TIMEOUT_SET_CYC
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	sbg_timer_if.timer tmr
);

	if (LIMIT < 2 || LIMIT >= (64'd1 << CNT_W)) begin : g_limit_check
		$error("sbg_low_timer: LIMIT does not fit the counter");
	end

	localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT - 1);

	logic [CNT_W-1:0] count;
	logic expired;

	// The count restarts on every edge and whenever the line is high.
	wire restart = tmr.line_edge | ~tmr.line_low;
	wire at_last = (count == LAST);
	wire [CNT_W-1:0] next_count = restart ? '0 : (at_last ? count : count + 1'b1);
	wire next_expired = ~restart & (count == LAST - 1'b1);

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			count <= '0;
			expired <= 1'b0;
		end else begin
			count <= next_count;
			expired <= next_expired;
		end
	end

	assign tmr.expired = expired;

endmodule

`default_nettype wire

/* File: sbg_timeout_guard.sv */
`default_nettype none

module sbg_timeout_guard import sbg_pkg::*; #(
	parameter int unsigned TIMEOUT_CYC = TIMEOUT_SET_CYC,
	parameter int unsigned FILT_LEN = SPIKE_CYC + 1
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic bus_clock_line_i,
	input wire logic bus_data_line_i,
	output logic bus_clock_line_o,
	output logic bus_clock_line_oe_o,
	output logic bus_data_line_o,
	output logic bus_data_line_oe_o,
	input wire logic [2:0] mode_req_i,
	input wire logic fast_class_i,
	input wire logic sda_timeout_en_i,
	input wire logic sda_drive_req_i,
	output logic scl_filt_o,
	output logic sda_filt_o,
	output logic start_o,
	output logic stop_o,
	output logic busy_o,
	output logic recover_o,
	output logic protocol_reset_o,
	output logic bus_idle_o,
	output logic [2:0] mode_o,
	output logic i2c_en_o,
	output logic smbus_en_o,
	output logic spi_en_o,
	output logic master_en_o
);

	if (FILT_LEN < 2 || FILT_LEN > 16) begin : g_filt_check
		$error("sbg_timeout_guard: FILT_LEN must be 2 to 16");
	end
	if (TIMEOUT_CYC < 2 || TIMEOUT_CYC >= (64'd1 << TIMER_W)) begin : g_timeout_check
		$error("sbg_timeout_guard: TIMEOUT_CYC does not fit the timer");
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Input spike filter.

	// In the fast class a level is taken only after FILT_LEN equal samples, so a spike that fits
	// between samples can never be seen as an edge. The slow class follows the last sample.
	function automatic logic filt_next(input logic [FILT_LEN-1:0] hist, input logic cur, input logic fast);
		logic res;
		res = cur;
		if (!fast) begin
			res = hist[0];
		end else if (&hist) begin
			res = 1'b1;
		end else if (~|hist) begin
			res = 1'b0;
		end
		return res;
	endfunction

	logic [FILT_LEN-1:0] scl_hist;
	logic [FILT_LEN-1:0] sda_hist;
	logic scl_filt;
	logic sda_filt;

	wire [FILT_LEN-1:0] next_scl_hist = {scl_hist[FILT_LEN-2:0], bus_clock_line_i};
	wire [FILT_LEN-1:0] next_sda_hist = {sda_hist[FILT_LEN-2:0], bus_data_line_i};
	wire next_scl_filt = filt_next(scl_hist, scl_filt, fast_class_i);
	wire next_sda_filt = filt_next(sda_hist, sda_filt, fast_class_i);

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			scl_hist <= {FILT_LEN{RST_LINE}};
			sda_hist <= {FILT_LEN{RST_LINE}};
			scl_filt <= RST_LINE;
			sda_filt <= RST_LINE;
		end else begin
			scl_hist <= next_scl_hist;
			sda_hist <= next_sda_hist;
			scl_filt <= next_scl_filt;
			sda_filt <= next_sda_filt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Protocol selection.

	logic [2:0] mode;
	sbg_state_e state;

	wire mode_valid = (mode_req_i == SBG_MODE_I2C) || (mode_req_i == SBG_MODE_SMBUS) ||
		(mode_req_i == SBG_MODE_SPI) || (mode_req_i == SBG_MODE_MASTER);
	// A new protocol is taken only outside a frame, and an unknown code turns every protocol off.
	wire mode_take = (state != SBG_ST_FRAME);
	wire [2:0] next_mode = mode_take ? (mode_valid ? mode_req_i : SBG_MODE_OFF) : mode;
	wire target_on = (mode == SBG_MODE_I2C) || (mode == SBG_MODE_SMBUS);

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Bus conditions and timeout counters.

	wire scl_edge = scl_filt ^ next_scl_filt;
	wire sda_edge = sda_filt ^ next_sda_filt;
	wire start_cond = target_on & scl_filt & next_scl_filt & sda_filt & ~next_sda_filt;
	wire stop_cond = target_on & scl_filt & next_scl_filt & ~sda_filt & next_sda_filt;

	sbg_timer_if scl_tmr ();
	sbg_timer_if sda_tmr ();

	assign scl_tmr.line_low = target_on & ~scl_filt;
	assign scl_tmr.line_edge = scl_edge;
	assign sda_tmr.line_low = target_on & sda_timeout_en_i & ~sda_filt;
	assign sda_tmr.line_edge = sda_edge;

	sbg_low_timer #(
		.CNT_W(TIMER_W),
		.LIMIT(TIMEOUT_CYC)
	) u_scl_timer (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.tmr(scl_tmr)
	);

	sbg_low_timer #(
		.CNT_W(TIMER_W),
		.LIMIT(TIMEOUT_CYC)
	) u_sda_timer (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.tmr(sda_tmr)
	);

	wire timeout_evt = scl_tmr.expired | sda_tmr.expired;

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Transfer state.

	sbg_state_e next_state;

	// A timeout wins over a START or STOP seen in the same cycle, so the abort is never lost.
	always_comb begin
		next_state = state;
		case (state)
			SBG_ST_IDLE: begin
				if (start_cond) begin
					next_state = SBG_ST_FRAME;
				end
			end
			SBG_ST_FRAME: begin
				if (stop_cond) begin
					next_state = SBG_ST_IDLE;
				end else if (start_cond) begin
					next_state = SBG_ST_FRAME;
				end
			end
			SBG_ST_RECOVER: begin
				if (start_cond) begin
					next_state = SBG_ST_FRAME;
				end else if (stop_cond) begin
					next_state = SBG_ST_IDLE;
				end
			end
			default: begin
				next_state = SBG_ST_IDLE;
			end
		endcase
		if (timeout_evt) begin
			next_state = SBG_ST_RECOVER;
		end
		if (!target_on) begin
			next_state = SBG_ST_IDLE;
		end
	end

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Bus free detection.

	logic [IDLE_W-1:0] idle_count;
	localparam logic [IDLE_W-1:0] IDLE_LAST = IDLE_W'(IDLE_CYC);

	wire lines_high = scl_filt & sda_filt;
	wire idle_full = (idle_count == IDLE_LAST);
	wire [IDLE_W-1:0] next_idle_count = !lines_high ? '0 : (idle_full ? idle_count : idle_count + 1'b1);
	wire next_bus_idle = lines_high & idle_full;

	////////////////////////////////////////////////////////////////////////////////////////////////////
	// Pin drive.

	// Data is pulled low only for the protocol engine inside a live frame; the abort releases it
	// in the same cycle the timeout fires.
	wire next_sda_oe = target_on & sda_drive_req_i & (state == SBG_ST_FRAME) & ~timeout_evt;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			state <= SBG_ST_IDLE;
			mode <= RST_MODE;
			idle_count <= '0;
			bus_idle_o <= RST_PULSE;
			start_o <= RST_PULSE;
			stop_o <= RST_PULSE;
			protocol_reset_o <= RST_PULSE;
			bus_data_line_oe_o <= 1'b0;
		end else begin
			state <= next_state;
			mode <= next_mode;
			idle_count <= next_idle_count;
			bus_idle_o <= next_bus_idle;
			start_o <= start_cond;
			stop_o <= stop_cond;
			protocol_reset_o <= timeout_evt;
			bus_data_line_oe_o <= next_sda_oe;
		end
	end

	// The clock line is never driven and no START, STOP or clock pulse is made here.
	always_ff @(posedge core_clk_i) begin
		bus_clock_line_o <= 1'b0;
		bus_clock_line_oe_o <= 1'b0;
		bus_data_line_o <= 1'b0;
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			scl_filt_o <= RST_LINE;
			sda_filt_o <= RST_LINE;
			busy_o <= 1'b0;
			recover_o <= 1'b0;
		end else begin
			scl_filt_o <= next_scl_filt;
			sda_filt_o <= next_sda_filt;
			busy_o <= (next_state == SBG_ST_FRAME);
			recover_o <= (next_state == SBG_ST_RECOVER);
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			mode_o <= RST_MODE;
			i2c_en_o <= 1'b0;
			smbus_en_o <= 1'b0;
			spi_en_o <= 1'b0;
			master_en_o <= 1'b0;
		end else begin
			mode_o <= next_mode;
			i2c_en_o <= (next_mode == SBG_MODE_I2C);
			smbus_en_o <= (next_mode == SBG_MODE_SMBUS);
			spi_en_o <= (next_mode == SBG_MODE_SPI);
			master_en_o <= (next_mode == SBG_MODE_MASTER);
		end
	end

endmodule

`default_nettype wire

/* File: sbg_timeout_guard_dummy_unused.sv */
`default_nettype none
`default_nettype wire

/* File: sbg_guard_sva.sv */
`default_nettype none
module sbg_guard_sva import sbg_pkg::*; #(
	parameter int unsigned TIMEOUT_CYC = TIMEOUT_SET_CYC
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic bus_clock_line_i,
	input wire logic fast_class_i,
	input wire logic sda_timeout_en_i,
	input wire logic bus_clock_line_oe_o,
	input wire logic bus_data_line_o,
	input wire logic bus_data_line_oe_o,
	input wire logic scl_filt_o,
	input wire logic busy_o,
	input wire logic recover_o,
	input wire logic protocol_reset_o,
	input wire logic i2c_en_o,
	input wire logic smbus_en_o,
	input wire logic spi_en_o,
	input wire logic master_en_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int lo_cnt;
	// Counts cycles of filtered clock low while a target mode is on.
	always_ff @(posedge core_clk_i) begin
		lo_cnt <= (rst_i || scl_filt_o || !(i2c_en_o || smbus_en_o)) ? 0 : lo_cnt + 1;
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	clk_not_driven_a: assert property (!bus_clock_line_oe_o)
		else $error("clock line driven");
	data_pull_only_a: assert property (bus_data_line_oe_o |-> !bus_data_line_o)
		else $error("data line driven high");
	one_protocol_a: assert property ($onehot0({i2c_en_o, smbus_en_o, spi_en_o, master_en_o}))
		else $error("several protocols enabled");
	reset_pulse_single_a: assert property (protocol_reset_o |=> !protocol_reset_o)
		else $error("protocol reset longer than one cycle");
	timeout_release_a: assert property (protocol_reset_o |-> recover_o && !busy_o && !bus_data_line_oe_o)
		else $error("bus not released on timeout");
	no_early_timeout_a: assert property (protocol_reset_o && !sda_timeout_en_i |->
		lo_cnt >= TIMEOUT_CYC - 2 && lo_cnt <= TIMEOUT_CYC + 3) else $error("timeout at wrong count");
	timeout_deadline_a: assert property (lo_cnt == TIMEOUT_CYC + 4 |-> recover_o)
		else $error("timeout missed");
	spike_filter_a: assert property ($past(fast_class_i) && !$stable(scl_filt_o) |->
		$past(bus_clock_line_i, 2) == scl_filt_o && $past(bus_clock_line_i, 3) == scl_filt_o)
		else $error("clock filter took a short pulse");
endmodule
bind sbg_timeout_guard sbg_guard_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) sbg_guard_sva_inst (.core_clk_i(core_clk_i),
	.rst_i(rst_i), .bus_clock_line_i(bus_clock_line_i), .fast_class_i(fast_class_i),
	.sda_timeout_en_i(sda_timeout_en_i), .bus_clock_line_oe_o(bus_clock_line_oe_o),
	.bus_data_line_o(bus_data_line_o), .bus_data_line_oe_o(bus_data_line_oe_o), .scl_filt_o(scl_filt_o),
	.busy_o(busy_o), .recover_o(recover_o), .protocol_reset_o(protocol_reset_o), .i2c_en_o(i2c_en_o),
	.smbus_en_o(smbus_en_o), .spi_en_o(spi_en_o), .master_en_o(master_en_o));
`default_nettype wire

/* File: sbg_host_model.sv */
`default_nettype none
module sbg_host_model (
	input wire logic core_clk_i,
	output var logic scl_low_o,
	output var logic sda_low_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
	end
	// Open-drain drive: a released line floats to the pull-up level.
	task automatic put(input logic c, input logic d, input int n);
		scl_low_o = !c;
		sda_low_o = !d;
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	// Phases of 15 cycles keep the clock near 333 kHz and high well under 50 us.
	task automatic bus_start();
		put(1'b1, 1'b1, 15);
		put(1'b1, 1'b0, 15);
		put(1'b0, 1'b0, 15);
	endtask
	task automatic bus_stop();
		put(1'b0, 1'b0, 15);
		put(1'b1, 1'b0, 15);
		put(1'b1, 1'b1, 15);
	endtask
endmodule
`default_nettype wire

/* File: tb_smbus_slave_timeout_guard.sv */
`default_nettype none
module tb_smbus_slave_timeout_guard import sbg_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned T = 50;
	logic core_clk_i, rst_i, fast_i, sdat_en, drv_req, scl_low, sda_low;
	logic [2:0] mode_req_i;
	logic scl_oe, scl_o, sda_oe, sda_o, scl_f, rec, busy, preset, start, i2c, smb, spi, mst;
	logic sda_f, stop, idle;
	logic [2:0] mode;
	wire logic scl_w, sda_w;
	int miscompares = 0, n_checks = 0, n_rst = 0, n_start = 0, n_low = 0, cyc = 0, n_stop = 0;
	assign scl_w = !(scl_low || (scl_oe && !scl_o));
	assign sda_w = !(sda_low || (sda_oe && !sda_o));
	initial begin
		core_clk_i = 1'b0;
		forever #50 core_clk_i = !core_clk_i;
	end
	sbg_timeout_guard #(.TIMEOUT_CYC(T)) sbg_timeout_guard_inst (.core_clk_i(core_clk_i), .rst_i(rst_i),
		.bus_clock_line_i(scl_w), .bus_data_line_i(sda_w), .bus_clock_line_o(scl_o), .bus_clock_line_oe_o(scl_oe),
		.bus_data_line_o(sda_o), .bus_data_line_oe_o(sda_oe), .mode_req_i(mode_req_i), .fast_class_i(fast_i),
		.sda_timeout_en_i(sdat_en), .sda_drive_req_i(drv_req), .scl_filt_o(scl_f), .sda_filt_o(sda_f),
		.start_o(start), .stop_o(stop), .busy_o(busy), .recover_o(rec), .protocol_reset_o(preset),
		.bus_idle_o(idle), .mode_o(mode), .i2c_en_o(i2c), .smbus_en_o(smb), .spi_en_o(spi), .master_en_o(mst));
	sbg_host_model sbg_host_model_inst (.core_clk_i(core_clk_i), .scl_low_o(scl_low), .sda_low_o(sda_low));
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	always @(posedge core_clk_i) begin
		cyc++;
		if (preset === 1'b1) n_rst++;
		if (start === 1'b1) n_start++;
		if (stop === 1'b1) n_stop++;
		if (scl_f === 1'b0) n_low++;
		if (cyc > 5000) begin
			miscompares++;
			print_verdict();
		end
	end
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask
	task automatic t_mode();
		for (int m = 0; m < 8; m++) begin
			mode_req_i = 3'(m);
			w(3);
			chk("enables", (m >= 1 && m <= 4) ? 8'h08 >> (m - 1) : 8'h00, {4'h0, i2c, smb, spi, mst});
			chk("mode", (m >= 1 && m <= 4) ? 8'(m) : 8'h00, {5'h0, mode});
		end
		mode_req_i = 3'h2;
		w(3);
	endtask
	task automatic t_spike();
		int n0;
		n0 = n_low;
		sbg_host_model_inst.put(1'b0, 1'b1, 1);
		sbg_host_model_inst.put(1'b1, 1'b1, 10);
		chk("fast spike", 8'h00, 8'(n_low - n0));
		fast_i = 1'b0;
		n0 = n_low;
		sbg_host_model_inst.put(1'b0, 1'b1, 1);
		sbg_host_model_inst.put(1'b1, 1'b1, 10);
		chk("slow pulse", 8'h01, 8'(n_low - n0));
		fast_i = 1'b1;
	endtask
	task automatic t_timeout();
		int r0;
		int s0;
		r0 = n_rst;
		sbg_host_model_inst.bus_start();
		drv_req = 1'b1;
		w(2);
		chk("data pulled", 8'h01, {7'h0, sda_oe});
		sbg_host_model_inst.put(1'b0, 1'b1, T + 20);
		chk("timeouts", 8'(r0 + 1), 8'(n_rst));
		chk("after timeout", 8'h01, {5'h0, sda_oe, busy, rec});
		drv_req = 1'b0;
		s0 = n_stop;
		sbg_host_model_inst.bus_stop();
		chk("recover", 8'h00, {7'h0, rec});
		chk("stops", 8'(s0 + 1), 8'(n_stop));
		r0 = n_start;
		sbg_host_model_inst.bus_start();
		chk("restart", 8'(r0 + 1), 8'(n_start));
		chk("busy", 8'h01, {7'h0, busy});
		sbg_host_model_inst.bus_stop();
	endtask
	task automatic t_short();
		int r0;
		r0 = n_rst;
		sbg_host_model_inst.put(1'b0, 1'b1, T - 10);
		sbg_host_model_inst.put(1'b1, 1'b1, 15);
		sbg_host_model_inst.put(1'b0, 1'b1, T - 10);
		sbg_host_model_inst.put(1'b1, 1'b1, 15);
		chk("short lows", 8'(r0), 8'(n_rst));
	endtask
	task automatic t_data(input logic en);
		int r0;
		sdat_en = en;
		r0 = n_rst;
		sbg_host_model_inst.put(1'b1, 1'b0, T + 20);
		chk("data filt", 8'h00, {7'h0, sda_f});
		sbg_host_model_inst.put(1'b1, 1'b1, 15);
		chk("data timeout", 8'(r0 + int'(en)), 8'(n_rst));
	endtask
	// A reset inside a live frame must drop the drive and every enable, and drive requests stay refused after it.
	task automatic t_reset();
		sbg_host_model_inst.bus_start();
		drv_req = 1'b1;
		w(2);
		chk("before reset", 8'h03, {6'h0, sda_oe, busy});
		rst_i = 1'b1;
		w(2);
		rst_i = 1'b0;
		chk("reset outs", 8'h00, {sda_oe, busy, rec, start, i2c, smb, spi, mst});
		chk("reset mode", 8'h00, {5'h0, mode});
		w(4);
		chk("drive refused", 8'h04, {5'h0, smb, sda_oe, busy});
		drv_req = 1'b0;
		sbg_host_model_inst.bus_stop();
	endtask
	task automatic t_idle();
		sbg_host_model_inst.put(1'b0, 1'b1, 5);
		sbg_host_model_inst.put(1'b1, 1'b1, IDLE_CYC);
		chk("idle early", 8'h00, {7'h0, idle});
		w(10);
		chk("bus idle", 8'h01, {7'h0, idle});
		sbg_host_model_inst.put(1'b0, 1'b1, 5);
		chk("idle drop", 8'h00, {7'h0, idle});
		sbg_host_model_inst.put(1'b1, 1'b1, 15);
	endtask
	initial begin
		rst_i = 1'b1;
		mode_req_i = 3'h0;
		fast_i = 1'b1;
		sdat_en = 1'b0;
		drv_req = 1'b0;
		w(2);
		rst_i = 1'b0;
		chk("idle outs", 8'h00, {scl_oe, sda_oe, rec, busy, i2c, smb, spi, mst});
		chk("scl filt", 8'h01, {7'h0, scl_f});
		t_mode();
		t_spike();
		t_timeout();
		t_reset();
		t_short();
		t_data(1'b1);
		t_data(1'b0);
		t_idle();
		print_verdict();
	end
endmodule
`default_nettype wire
